/* design/encoder_loss_monitor.sv */
`default_nettype none

// Function
// - Low-speed fault when either condition set holds.
// - Set one: slow, stalled, torque limited, delayed.
// - Set two: slow, last sample slow, B lost.
// - Zero threshold disables all loss monitoring.
// - Reload limits on start-up change or optimisation.
// - Low-speed delay spans zero to 64 seconds.
// - Zero delay disables low-speed loss detection.
// - High-speed detection stays on without low-speed.
// - Low-speed checks only below the threshold.
// - Encoder modes are codes 21 and 23.
// - Publish measured rotor speed.
// - Publish rotor angle, absent for single channel.
// - Five status bits, active through single edge.
// - High-speed fault after fixed 40 ms delay.
// - Reaction is coast stop or sensorless alarm.
module encoder_loss_monitor
  import encoder_loss_pkg::*;
#(
  parameter int SAMPLE_CYCLES = SAMPLE_PERIOD_CYCLES,
  parameter int MS_CYCLES = MS_TICK_CYCLES,
  parameter int PULSES_PER_REV = PULSES_PER_REV_DEFAULT
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic enc_a_i,
  input wire logic enc_b_i,
  input wire logic encoder_enable_i,
  input wire logic single_channel_i,
  input wire logic single_edge_i,
  input wire logic [7:0] control_mode_selector_i,
  input wire logic [15:0] speed_difference_threshold_i,
  input wire logic [15:0] low_speed_loss_delay_i,
  input wire logic [15:0] motor_startup_time_i,
  input wire logic speed_loop_optimisation_request_i,
  input wire logic loss_reaction_select_i,
  input wire logic setpoint_positive_i,
  input wire logic torque_limited_i,
  input wire logic fault_ack_i,
  output logic encoder_loss_fault_o,
  output logic coast_stop_o,
  output logic loss_alarm_o,
  output logic sensorless_vector_control_o,
  output logic [15:0] measured_rotor_speed_o,
  output logic [15:0] rotor_angle_value_o,
  output logic [15:0] encoder_status_word_o
);

  // ----------------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------------
  // The angle counter is 16 bits wide and the time bases need one cycle.
  if (PULSES_PER_REV < 1 || PULSES_PER_REV > 16384) begin : g_ppr_check
    $error("PULSES_PER_REV must lie in 1..16384");
  end
  if (SAMPLE_CYCLES < 1 || MS_CYCLES < 1) begin : g_time_check
    $error("SAMPLE_CYCLES and MS_CYCLES must be at least 1");
  end

  // Last angle before the wrap: edges per revolution in quadrature counting, less one.
  localparam logic [15:0] ANGLE_WRAP = 16'(PULSES_PER_REV * 4 - 1);

  // Absolute difference of two frequency samples.
  function automatic logic [15:0] abs_diff(input logic [15:0] x,
                                           input logic [15:0] y);
    abs_diff = (x > y) ? (x - y) : (y - x);
  endfunction

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  logic a_meta, a_sync, a_last; // Channel A, two stages and history.
  logic b_meta, b_sync, b_last; // Channel B, two stages and history.

  // Encoder pins are asynchronous; only the second stage is used.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      {a_meta, a_sync, a_last} <= 3'h0;
      {b_meta, b_sync, b_last} <= 3'h0;
    end else begin
      {a_meta, a_sync, a_last} <= {enc_a_i, a_meta, a_sync};
      {b_meta, b_sync, b_last} <= {enc_b_i, b_meta, b_sync};
    end
  end

  wire a_edge = a_sync ^ a_last;
  wire b_edge = (b_sync ^ b_last) && !single_channel_i;
  // Forward when the moving channel differs from the other after A moves.
  wire fwd = a_edge ? (a_sync ^ b_sync) : !(a_sync ^ b_sync);
  // Single edge measurement counts only rising edges of channel A.
  wire counted_edge = single_edge_i ? (a_sync && !a_last)
                                    : (a_edge || b_edge);

  // ----------------------------------------------------------------------
  // Time bases
  // ----------------------------------------------------------------------
  logic [31:0] sample_count; // Cycles into the sampling period.
  logic [31:0] ms_count; // Cycles into the delay time step.
  wire sample_strobe = (sample_count == 32'(SAMPLE_CYCLES - 1));
  wire ms_tick = (ms_count == 32'(MS_CYCLES - 1));

  // Free-running dividers for sampling and delay timing.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sample_count <= 32'h0;
      ms_count <= 32'h0;
    end else begin
      sample_count <= sample_strobe ? 32'h0 : sample_count + 32'h1;
      ms_count <= ms_tick ? 32'h0 : ms_count + 32'h1;
    end
  end

  // ----------------------------------------------------------------------
  // Frequency sampling
  // ----------------------------------------------------------------------
  logic [15:0] edge_count; // Edges in the running period, saturating.
  logic [15:0] freq_now; // Latest sampled frequency, edges per period.
  logic [15:0] freq_prev; // The sample before it.
  logic [15:0] angle; // Position within one revolution.

  // Edges of a period become the sample at its end.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      edge_count <= 16'h0;
      freq_now <= 16'h0;
      freq_prev <= 16'h0;
    end else if (sample_strobe) begin
      edge_count <= 16'h0;
      freq_now <= edge_count;
      freq_prev <= freq_now;
    end else if (counted_edge && edge_count != 16'hffff) begin
      edge_count <= edge_count + 16'h1;
    end
  end

  // Angle wraps at one revolution in either direction.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      angle <= 16'h0;
    end else if (a_edge || b_edge) begin
      if (fwd) begin
        angle <= (angle == ANGLE_WRAP) ? 16'h0 : angle + 16'h1;
      end else begin
        angle <= (angle == 16'h0) ? ANGLE_WRAP : angle - 16'h1;
      end
    end
  end

  // Actual frequency smooths the last two samples.
  wire [16:0] freq_sum = {1'b0, freq_now} + {1'b0, freq_prev};
  wire [15:0] actual_freq = freq_sum[16:1];
  wire [15:0] freq_step = abs_diff(freq_now, freq_prev);

  // ----------------------------------------------------------------------
  // Channel B supervision
  // ----------------------------------------------------------------------
  logic [3:0] a_since_b; // A edges seen since the last B edge.

  // B is lost when A keeps moving and B stays still.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      a_since_b <= 4'h0;
    end else if (b_edge || single_channel_i) begin
      a_since_b <= 4'h0;
    end else if (a_edge && a_since_b != B_FAULT_EDGES) begin
      a_since_b <= a_since_b + 4'h1;
    end
  end
  wire b_fault = (a_since_b == B_FAULT_EDGES);

  // ----------------------------------------------------------------------
  // Limit reload
  // ----------------------------------------------------------------------
  logic [15:0] thr_eff; // Threshold in force.
  logic [15:0] delay_eff; // Low-speed delay in force, milliseconds.
  logic [15:0] startup_last; // Start-up time seen last cycle.
  logic opt_last; // Optimisation request seen last cycle.
  logic load_pending; // Forces a first load after reset.
  wire opt_rise = speed_loop_optimisation_request_i && !opt_last;
  wire reload = load_pending || opt_rise ||
                (motor_startup_time_i != startup_last);
  // The delay is clipped to its documented span.
  wire [15:0] delay_clip = (low_speed_loss_delay_i > LOW_SPEED_DELAY_MAX_MS)
                           ? LOW_SPEED_DELAY_MAX_MS : low_speed_loss_delay_i;

  // Limits change only on a reload, so a half-written value is never used.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      thr_eff <= 16'h0;
      delay_eff <= 16'h0;
      startup_last <= 16'h0;
      opt_last <= 1'b0;
      load_pending <= 1'b1;
    end else begin
      startup_last <= motor_startup_time_i;
      opt_last <= speed_loop_optimisation_request_i;
      load_pending <= 1'b0;
      if (reload) begin
        thr_eff <= speed_difference_threshold_i;
        delay_eff <= delay_clip;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Loss conditions
  // ----------------------------------------------------------------------
  wire mode_ok = (control_mode_selector_i == MODE_SPEED_ENCODER) ||
                 (control_mode_selector_i == MODE_TORQUE_ENCODER);
  wire enc_active = encoder_enable_i && mode_ok;
  wire monitor_on = enc_active && (thr_eff != 16'h0);
  // High-speed path ignores the low-speed delay entirely.
  wire hs_cond = monitor_on && (actual_freq > thr_eff) &&
                 (freq_step > thr_eff);
  // Low-speed path needs a non-zero delay and a slow shaft.
  wire low_zone = monitor_on && (delay_eff != 16'h0) &&
                  (actual_freq < thr_eff);
  wire speed_zero = (freq_now == 16'h0);
  wire hs_expired;
  wire ls_expired;
  wire case1 = low_zone && speed_zero && torque_limited_i &&
               ls_expired;
  wire case2 = low_zone && (freq_now < thr_eff) && b_fault;
  wire ls_loss = case1 || case2;
  wire fault_set = hs_expired || ls_loss;

  // Fixed delay before a high-speed loss is reported.
  hold_timer u_hs_timer (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .tick_i(ms_tick),
    .run_i(hs_cond),
    .limit_i(HIGH_SPEED_DELAY_MS),
    .expired_o(hs_expired)
  );

  // Stall with a positive setpoint must outlast the programmed delay.
  hold_timer u_ls_timer (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .tick_i(ms_tick),
    .run_i(low_zone && speed_zero && setpoint_positive_i),
    .limit_i(delay_eff),
    .expired_o(ls_expired)
  );

  // ----------------------------------------------------------------------
  // Fault latch and outputs
  // ----------------------------------------------------------------------
  logic fault; // Latched encoder-loss fault.
  logic ls_flag; // Latched cause: low-speed path.
  // A new loss in the acknowledge cycle wins over the acknowledge.
  wire next_fault = fault_set || (fault && !fault_ack_i);
  wire next_ls_flag = ls_loss || (ls_flag && !fault_ack_i);
  wire [15:0] next_status = {11'h0, single_edge_i, next_ls_flag,
                             enc_active && !next_fault && !b_fault,
                             next_fault, enc_active};

  // Every output is registered so the far side sees clean levels.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      fault <= 1'b0;
      ls_flag <= 1'b0;
      encoder_loss_fault_o <= 1'b0;
      coast_stop_o <= 1'b0;
      loss_alarm_o <= 1'b0;
      sensorless_vector_control_o <= 1'b0;
      measured_rotor_speed_o <= 16'h0;
      rotor_angle_value_o <= 16'h0;
      encoder_status_word_o <= STATUS_RESET;
    end else begin
      fault <= next_fault;
      ls_flag <= next_ls_flag;
      encoder_loss_fault_o <= next_fault;
      coast_stop_o <= next_fault &&
                      (loss_reaction_select_i == REACT_COAST_STOP);
      loss_alarm_o <= next_fault &&
                      (loss_reaction_select_i == REACT_SENSORLESS);
      sensorless_vector_control_o <= next_fault &&
                      (loss_reaction_select_i == REACT_SENSORLESS);
      measured_rotor_speed_o <= freq_now;
      // No angle can be known from one channel.
      rotor_angle_value_o <= single_channel_i ? 16'h0 : angle;
      encoder_status_word_o <= next_status;
    end
  end

endmodule

`default_nettype wire

/* design/encoder_loss_pkg.sv */
`default_nettype none

package encoder_loss_pkg;

  // ----------------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------------
  // Core clock rate in hertz.
  localparam int CLK_HZ = 100_000_000;
  // One time base step of the delay timers, in microseconds.
  localparam int MS_TICK_US = 1000;
  // Cycles per delay timer step, derived from the rate.
  localparam int MS_TICK_CYCLES = (CLK_HZ / 1_000_000) * MS_TICK_US;
  // Frequency sampling period, in microseconds.
  localparam int SAMPLE_PERIOD_US = 1000;
  // Cycles per sampling period.
  localparam int SAMPLE_PERIOD_CYCLES =
    (CLK_HZ / 1_000_000) * SAMPLE_PERIOD_US;
  // Fixed high-speed loss delay, in milliseconds.
  localparam logic [15:0] HIGH_SPEED_DELAY_MS = 16'h0028;
  // Largest low-speed loss delay, in milliseconds (64.000 s).
  localparam logic [15:0] LOW_SPEED_DELAY_MAX_MS = 16'hfa00;

  // ----------------------------------------------------------------------
  // Encoder settings
  // ----------------------------------------------------------------------
  // Default pulses per revolution of the encoder.
  localparam int PULSES_PER_REV_DEFAULT = 1024;
  // Channel A edges without a channel B edge that mark channel B as lost.
  localparam logic [3:0] B_FAULT_EDGES = 4'h4;

  // ----------------------------------------------------------------------
  // Control mode selector codes
  // ----------------------------------------------------------------------
  localparam logic [7:0] MODE_SPEED_ENCODER = 8'h15;  // Speed loop, 21.
  localparam logic [7:0] MODE_TORQUE_ENCODER = 8'h17; // Torque loop, 23.

  // ----------------------------------------------------------------------
  // Loss reaction selector codes
  // ----------------------------------------------------------------------
  localparam logic REACT_COAST_STOP = 1'b0;
  localparam logic REACT_SENSORLESS = 1'b1;

  // ----------------------------------------------------------------------
  // Encoder status word layout
  // ----------------------------------------------------------------------
  localparam int STAT_ACTIVE = 0;
  localparam int STAT_FAULT = 1;
  localparam int STAT_SIGNAL_OK = 2;
  localparam int STAT_LOW_SPEED_LOSS = 3;
  localparam int STAT_SINGLE_EDGE = 4;
  localparam logic [15:0] STATUS_RESET = 16'h0000;

endpackage

`default_nettype wire

/* design/hold_timer.sv */
`default_nettype none

// Counts time steps while a condition holds and flags when the count has
// passed a programmed limit. Any gap in the condition restarts the count.
module hold_timer (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic tick_i,
  input wire logic run_i,
  input wire logic [15:0] limit_i,
  output logic expired_o
);

  // ----------------------------------------------------------------------
  // Step counter
  // ----------------------------------------------------------------------
  // Steps counted so far; it saturates so a long hold never wraps.
  logic [15:0] count;

  // Count only while the condition holds, stop once past the limit.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      count <= 16'h0000;
    end else if (!run_i) begin
      count <= 16'h0000;
    end else if (tick_i && count <= limit_i && count != 16'hffff) begin
      count <= count + 16'h0001;
    end
  end

  // Strictly longer than the limit, so the hold always exceeds it.
  assign expired_o = run_i && (count > limit_i);

endmodule

`default_nettype wire

/* test/quad_encoder_model.sv */
`default_nettype none
// ---------------------------------------------------------------------
// Quadrature encoder on the motor shaft
// ---------------------------------------------------------------------
module quad_encoder_model (
  input wire logic clk_i,
  input wire logic run_i,
  input wire logic [7:0] step_i,
  input wire logic b_dead_i,
  output logic enc_a_o,
  output logic enc_b_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [1:0] phase = 2'h0; // Gray position, one step is one edge.
  logic [7:0] wait_cnt = 8'h00; // Cycles since the last step.
  logic b_hold = 1'b0; // Channel B level while the wire is broken.
  // The shaft stands still unless run; a broken B keeps its last level.
  always @(posedge clk_i) begin
    if (run_i && wait_cnt + 8'h01 >= step_i) begin
      wait_cnt <= 8'h00;
      phase <= phase + 2'h1;
    end else if (run_i) begin
      wait_cnt <= wait_cnt + 8'h01;
    end
    if (!b_dead_i) begin
      b_hold <= phase[1] ^ phase[0];
    end
  end
  assign enc_a_o = phase[1];
  assign enc_b_o = b_dead_i ? b_hold : phase[1] ^ phase[0];
endmodule
`default_nettype wire

/* test/encoder_loss_monitor_properties.sv */
`default_nettype none
// ---------------------------------------------------------------------
// Port checker for the encoder loss monitor
// ---------------------------------------------------------------------
module encoder_loss_checker
  import encoder_loss_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic encoder_enable_i,
  input wire logic single_channel_i,
  input wire logic single_edge_i,
  input wire logic [7:0] control_mode_selector_i,
  input wire logic loss_reaction_select_i,
  input wire logic fault_ack_i,
  input wire logic encoder_loss_fault_o,
  input wire logic coast_stop_o,
  input wire logic loss_alarm_o,
  input wire logic sensorless_vector_control_o,
  input wire logic [15:0] rotor_angle_value_o,
  input wire logic [15:0] encoder_status_word_o
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  // Only the two feedback modes may ever launch a fault.
  wire mode_ok = control_mode_selector_i == MODE_SPEED_ENCODER ||
    control_mode_selector_i == MODE_TORQUE_ENCODER;
  // A fresh fault: clear at one edge, set at the next.
  sequence fault_rise;
    !encoder_loss_fault_o ##1 encoder_loss_fault_o;
  endsequence
  // A fault that has stood for two edges.
  sequence fault_held;
    encoder_loss_fault_o [*2];
  endsequence
  AST_FAULT_MODE: assert property (fault_rise |->
    $past(mode_ok) && $past(encoder_enable_i))
    else $error("fault rose outside an encoder mode");
  AST_FAULT_LATCH: assert property (
    encoder_loss_fault_o && !fault_ack_i |=> encoder_loss_fault_o)
    else $error("fault dropped without acknowledge");
  AST_FAULT_BIT: assert property (
    encoder_status_word_o[1] == encoder_loss_fault_o)
    else $error("status fault bit differs from fault");
  AST_LOW_BIT: assert property (
    encoder_status_word_o[3] |-> encoder_status_word_o[1])
    else $error("low speed bit without fault bit");
  AST_SIGNAL_OK: assert property (encoder_status_word_o[2] |->
    encoder_status_word_o[0] && !encoder_status_word_o[1])
    else $error("signal ok while inactive or faulted");
  AST_SINGLE_EDGE: assert property ($past(reset_n_i) |->
    encoder_status_word_o[4] == $past(single_edge_i))
    else $error("single edge bit does not follow setting");
  AST_REACTION: assert property (fault_held ##0
    $stable(loss_reaction_select_i) |->
    coast_stop_o == !loss_reaction_select_i &&
    loss_alarm_o == loss_reaction_select_i)
    else $error("reaction outputs do not match selection");
  AST_SENSORLESS: assert property (
    sensorless_vector_control_o == loss_alarm_o)
    else $error("sensorless output differs from alarm");
  AST_ANGLE_SINGLE: assert property (single_channel_i &&
    $past(single_channel_i) && $past(reset_n_i) |->
    rotor_angle_value_o == 16'h0000)
    else $error("angle shown for single channel encoder");
endmodule
bind encoder_loss_monitor encoder_loss_checker chk_u (
  .clk_i(clk_i), .reset_n_i(reset_n_i),
  .encoder_enable_i(encoder_enable_i),
  .single_channel_i(single_channel_i), .single_edge_i(single_edge_i),
  .control_mode_selector_i(control_mode_selector_i),
  .loss_reaction_select_i(loss_reaction_select_i),
  .fault_ack_i(fault_ack_i), .encoder_loss_fault_o(encoder_loss_fault_o),
  .coast_stop_o(coast_stop_o), .loss_alarm_o(loss_alarm_o),
  .sensorless_vector_control_o(sensorless_vector_control_o),
  .rotor_angle_value_o(rotor_angle_value_o),
  .encoder_status_word_o(encoder_status_word_o));
`default_nettype wire

/* test/tb_top.sv */
`default_nettype none
module tb_top
  import encoder_loss_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  // -------------------------------------------------------------------
  // Stimulus and observed signals
  // -------------------------------------------------------------------
  logic clk_i = 1'b0, reset_n_i = 1'b0, enc_a, enc_b, run = 1'b0;
  logic b_dead = 1'b0, enable = 1'b1, single_ch = 1'b0, single_edge = 1'b0;
  logic opt_req = 1'b0, sel = 1'b0, set_pos = 1'b0, torque_lim = 1'b0;
  logic ack = 1'b0, fault, coast, alarm, svc;
  logic [7:0] mode = 8'h15, step = 8'h0a;
  logic [15:0] thr = 16'h0000, dly = 16'h0000, startup = 16'h0000;
  logic [15:0] speed, angle, status;
  int bad_count = 0, total_checks = 0;
  int sample_phase = 0; // Cycle within the 100-cycle sampling period.
  // Small counts keep the run short: 100-cycle sample, 10-cycle ms tick.
  encoder_loss_monitor #(.SAMPLE_CYCLES(100), .MS_CYCLES(10)) DUT (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .enc_a_i(enc_a), .enc_b_i(enc_b),
    .encoder_enable_i(enable), .single_channel_i(single_ch),
    .single_edge_i(single_edge), .control_mode_selector_i(mode),
    .speed_difference_threshold_i(thr), .low_speed_loss_delay_i(dly),
    .motor_startup_time_i(startup),
    .speed_loop_optimisation_request_i(opt_req),
    .loss_reaction_select_i(sel), .setpoint_positive_i(set_pos),
    .torque_limited_i(torque_lim), .fault_ack_i(ack),
    .encoder_loss_fault_o(fault), .coast_stop_o(coast),
    .loss_alarm_o(alarm), .sensorless_vector_control_o(svc),
    .measured_rotor_speed_o(speed), .rotor_angle_value_o(angle),
    .encoder_status_word_o(status));
  quad_encoder_model enc_u (.clk_i(clk_i), .run_i(run), .step_i(step),
    .b_dead_i(b_dead), .enc_a_o(enc_a), .enc_b_o(enc_b));
  // Counts the sampling period so a scenario can start on its boundary.
  always @(posedge clk_i) begin
    sample_phase <= reset_n_i ? (sample_phase + 1) % 100 : 0;
  end
  // -------------------------------------------------------------------
  // Shared helpers
  // -------------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  // Case equality so that an unknown never passes.
  task automatic chk(input string name, input logic [15:0] exp,
                     input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask
  // Limits are taken when the start-up time moves or an optimisation request rises.
  task automatic reload(input logic [15:0] t, input logic [15:0] d);
    thr = t;
    dly = d;
    startup = startup + 16'h0001;
    cyc(3);
  endtask
  // Drop the fault after the cause is gone; B runs again to clear loss.
  task automatic recover();
    b_dead = 1'b0;
    cyc(60);
    run = 1'b0;
    set_pos = 1'b0;
    torque_lim = 1'b0;
    cyc(250);
    ack = 1'b1;
    cyc(1);
    ack = 1'b0;
    cyc(2);
    chk("fault cleared", 16'h0000, {15'h0000, fault});
  endtask
  // -------------------------------------------------------------------
  // Scenarios
  // -------------------------------------------------------------------
  task automatic t_idle();
    chk("idle status", 16'h0005, status);
    chk("idle speed", 16'h0000, speed);
    $display("test idle done");
  endtask
  // Ten edges per period at 4x counting, 2 or 3 rises of A single edge.
  task automatic t_speed();
    run = 1'b1;
    cyc(350);
    total_checks++;
    if ((speed >= 16'h0009 && speed <= 16'h000b) !== 1'b1) begin
      bad_count++;
      $display("wrong value speed expected 000a seen %h", speed);
    end
    single_edge = 1'b1;
    single_ch = 1'b1;
    cyc(350);
    total_checks++;
    if ((speed >= 16'h0002 && speed <= 16'h0003) !== 1'b1) begin
      bad_count++;
      $display("wrong value edge speed expected 0002 seen %h", speed);
    end
    chk("single edge bit", 16'h0001, {15'h0000, status[4]});
    chk("single angle", 16'h0000, angle);
    single_edge = 1'b0;
    single_ch = 1'b0;
    run = 1'b0;
    cyc(300);
    $display("test speed done");
  endtask
  // Channel B breaks at low speed; the fault is gated by mode and limit.
  task automatic t_case2(input logic [7:0] m, input logic [15:0] t,
                         input logic s, input logic e);
    reload(t, 16'h0064);
    mode = m;
    sel = s;
    b_dead = 1'b1;
    run = 1'b1;
    for (int i = 0; i < 600 && fault !== 1'b1; i++) cyc(1);
    cyc(2);
    chk("b loss fault", {15'h0000, e}, {15'h0000, fault});
    chk("low bit", {15'h0000, e}, {15'h0000, status[3]});
    chk("coast", {15'h0000, e & !s}, {15'h0000, coast});
    chk("alarm", {15'h0000, e & s}, {15'h0000, alarm});
    chk("sensorless", {15'h0000, e & s}, {15'h0000, svc});
    recover();
    $display("test channel b mode %h done", m);
  endtask
  // Stall at positive setpoint under torque limit for over 5 ms.
  task automatic t_case1();
    int n;
    reload(16'h0032, 16'h0005);
    mode = 8'h15;
    cyc(250);
    set_pos = 1'b1;
    torque_lim = 1'b1;
    for (n = 0; n < 1000 && fault !== 1'b1; n++) cyc(1);
    chk("stall fault", 16'h0001, {15'h0000, fault});
    total_checks++;
    // Five 10-cycle ticks must pass in full, plus tick phase and register.
    if (n < 52 || n > 61) begin
      bad_count++;
      $display("wrong value stall delay expected 52 to 61 seen %0d", n);
    end
    recover();
    // A zero delay taken by an optimisation request stops this path.
    dly = 16'h0000;
    opt_req = 1'b1;
    cyc(3);
    opt_req = 1'b0;
    set_pos = 1'b1;
    torque_lim = 1'b1;
    cyc(700);
    chk("no stall fault", 16'h0000, {15'h0000, fault});
    set_pos = 1'b0;
    torque_lim = 1'b0;
    $display("test stall done");
  endtask
  // Speed jumps every period; a zero delay leaves only the fast path.
  task automatic t_high();
    reload(16'h0014, 16'h0000);
    step = 8'h01;
    while (sample_phase != 0) cyc(1);
    for (int i = 0; i < 4; i++) begin
      run = ~run;
      cyc(100);
    end
    chk("early fast fault", 16'h0000, {15'h0000, fault});
    for (int i = 0; i < 4; i++) begin
      run = ~run;
      cyc(100);
    end
    chk("fast fault", 16'h0001, {15'h0000, fault});
    chk("fast low bit", 16'h0000, {15'h0000, status[3]});
    chk("fast coast", 16'h0001, {15'h0000, coast});
    run = 1'b0;
    step = 8'h0a;
    recover();
    $display("test high speed done");
  endtask
  // -------------------------------------------------------------------
  // Clock, reset, sequence and watchdog
  // -------------------------------------------------------------------
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    cyc(12);
    reset_n_i = 1'b1;
    cyc(4);
    t_idle();
    t_speed();
    t_case2(8'h15, 16'h0032, 1'b0, 1'b1);
    t_case2(8'h17, 16'h0032, 1'b1, 1'b1);
    t_case2(8'h14, 16'h0032, 1'b0, 1'b0);
    t_case2(8'h15, 16'h0000, 1'b0, 1'b0);
    t_case1();
    t_high();
    test_done();
  end
  // The tests need about 6200 cycles; a hang stops at 20000.
  initial begin
    cyc(20000);
    bad_count++;
    test_done();
  end
endmodule
`default_nettype wire
